// ### design/scp_pkg.sv
// Shared constants of the three-wire serial control port and its controller
// Operation
// - Writes sampled on rising, reads driven falling
// - One shared data pin, both directions
// - Active-low chip select frames each transfer
// - Select high: pin released, clock ignored
// - Cycle starts: select low, then rising edge
// - Sixteen-bit instruction word comes first
// - Instruction top bit set means read
// - Length code: one, two, three, streaming
// - Low thirteen bits give start address
// - Host sends exactly the coded byte count
// - First data byte uses instruction address
// - Host drives address bits 12:8 zero
// - Access all registers, either bit order
// - Address decrements msb-first, increments lsb-first
// - Streaming ends on select rise or 0xFF
// - Select rise mid-byte resets port state
// - Register 0x00 bits 2,6 select lsb-first
package scp_pkg;
   localparam int          CLK_NS        = 10;
   localparam int          INSTR_BITS    = 16;
   localparam int          RW_BIT        = 15;
   localparam int          LEN_HI        = 14;
   localparam int          LEN_LO        = 13;
   localparam int          ADDR_W        = 13;
   localparam logic [1:0]  LEN_STREAM    = 2'h3;
   localparam logic [7:0]  CFG_ADDR      = 8'h00;
   localparam int          CFG_LSB_A     = 2;
   localparam int          CFG_LSB_B     = 6;
   localparam logic [7:0]  CFG_RESET     = 8'h18;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  LAST_ADDR     = 8'hFF;
   localparam int          STREAM_BYTES  = 4;
   // Serial clock half period chosen so read data settles through both synchronisers
   localparam int          SCLK_HALF_NS  = 80;
   localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CS_SETUP_NS   = 5;
   localparam int          CS_SETUP_CYC  = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CS_HOLD_NS    = 2;
   localparam int          CS_HOLD_CYC   = (CS_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_ADDR      = 8'h04;
   localparam logic [7:0]  OFS_TXD       = 8'h08;
   localparam logic [7:0]  OFS_RXD       = 8'h0C;
   localparam logic [7:0]  OFS_STAT      = 8'h10;
   localparam int          CTRL_GO       = 0;
   localparam int          CTRL_RW       = 1;
   localparam int          CTRL_LEN      = 2;
   localparam int          CTRL_LSB      = 4;
   localparam int          STAT_BUSY     = 0;
   localparam int          STAT_DONE     = 1;
endpackage : scp_pkg

// ### design/scp_if.sv
// Pin bundle joining the port device and its host controller
interface scp_if;
   logic sclk;
   logic cs_n;
   logic host_sdio;
   logic host_oe;
   logic dev_sdio;
   logic dev_oe;
   logic sdio;
   // Undriven wire settles low in this model
   assign sdio = dev_oe ? dev_sdio : (host_oe ? host_sdio : 1'b0);
   modport dev (input sclk, input cs_n, input sdio, output dev_sdio, output dev_oe);
   modport host (output sclk, output cs_n, output host_sdio, output host_oe, input sdio);
endinterface : scp_if

// ### design/scp_device.sv
// Serial control port device end with its configuration register array
//
// Implementation choices: the 256-entry address map and the update outputs for written registers.
module scp_device
   import scp_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   scp_if.dev              link,
   output logic            lsb_first_o,
   output logic            busy_o,
   output logic            upd_valid_o,
   output logic [7:0]      upd_addr_o,
   output logic [7:0]      upd_data_o
);
   typedef enum logic [1:0] {
      SCP_IDLE,
      SCP_INSTR,
      SCP_DATA,
      SCP_DONE
   } scp_state_t;

   scp_state_t  state_r;
   logic        sclk_m_r;
   logic        sclk_s_r;
   logic        sclk_d_r;
   logic        cs_m_r;
   logic        cs_s_r;
   logic        cs_d_r;
   logic        sdi_m_r;
   logic        sdi_s_r;
   logic [3:0]  cnt_r;
   logic [15:0] ish_r;
   logic [7:0]  dsh_r;
   logic        rd_r;
   logic [1:0]  len_r;
   logic [1:0]  left_r;
   logic [7:0]  addr_r;
   logic        sdo_r;
   logic        oe_r;
   logic        upd_r;
   logic [7:0]  upd_addr_r;
   logic [7:0]  upd_data_r;
   logic [7:0]  mem [256];

   logic        lsb;
   logic        rise;
   logic        fall;
   logic        cs_rise;
   logic        cs_fall;
   logic [15:0] instr_nxt;
   logic [7:0]  byte_nxt;
   logic [7:0]  addr_nxt;
   logic [2:0]  bidx;
   logic        byte_end;
   logic        last_byte;

   // Order is read live, so a write to 0x00 affects the very next byte
   assign lsb = mem[CFG_ADDR][CFG_LSB_A] | mem[CFG_ADDR][CFG_LSB_B];

   // Edges only count while selected
   assign rise    = sclk_s_r & ~sclk_d_r & ~cs_s_r;
   assign fall    = ~sclk_s_r & sclk_d_r & ~cs_s_r;
   assign cs_rise = cs_s_r & ~cs_d_r;
   assign cs_fall = ~cs_s_r & cs_d_r;

   always_comb begin
      if (lsb) begin
         instr_nxt = {sdi_s_r, ish_r[15:1]};
         byte_nxt  = {sdi_s_r, dsh_r[7:1]};
      end else begin
         instr_nxt = {ish_r[14:0], sdi_s_r};
         byte_nxt  = {dsh_r[6:0], sdi_s_r};
      end
   end

   assign addr_nxt = lsb ? 8'(addr_r + 8'h01) : 8'(addr_r - 8'h01);
   assign bidx     = lsb ? cnt_r[2:0] : 3'(3'h7 - cnt_r[2:0]);
   assign byte_end = (state_r == SCP_DATA) && rise && (cnt_r == 4'h7);

   always_comb begin
      if (len_r == LEN_STREAM) begin
         last_byte = (addr_r == LAST_ADDR);
      end else begin
         last_byte = (left_r == 2'h0);
      end
   end

   // Pins are asynchronous to mclk; the first flops feed only the second
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         cs_m_r   <= 1'b1;
         cs_s_r   <= 1'b1;
         cs_d_r   <= 1'b1;
         sdi_m_r  <= 1'b0;
         sdi_s_r  <= 1'b0;
      end else begin
         sclk_m_r <= link.sclk;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         cs_m_r   <= link.cs_n;
         cs_s_r   <= cs_m_r;
         cs_d_r   <= cs_s_r;
         sdi_m_r  <= link.sdio;
         sdi_s_r  <= sdi_m_r;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= SCP_IDLE;
         cnt_r   <= 4'h0;
         ish_r   <= 16'h0000;
         dsh_r   <= 8'h00;
         rd_r    <= 1'b0;
         len_r   <= 2'h0;
         left_r  <= 2'h0;
         addr_r  <= 8'h00;
      end else if (cs_rise) begin
         // A byte-boundary rise only stalls a counted data phase; streaming ends on it
         if (state_r != SCP_DATA || cnt_r != 4'h0 || len_r == LEN_STREAM) begin
            state_r <= SCP_IDLE;
            cnt_r   <= 4'h0;
         end
      end else if (rise) begin
         case (state_r)
            SCP_IDLE: begin
               ish_r   <= instr_nxt;
               cnt_r   <= 4'h1;
               state_r <= SCP_INSTR;
            end
            SCP_INSTR: begin
               ish_r <= instr_nxt;
               if (cnt_r == 4'hF) begin
                  cnt_r   <= 4'h0;
                  state_r <= SCP_DATA;
                  rd_r    <= instr_nxt[RW_BIT];
                  len_r   <= instr_nxt[LEN_HI:LEN_LO];
                  left_r  <= instr_nxt[LEN_HI:LEN_LO];
                  // Upper address bits are don't-care for a 256-entry map
                  addr_r  <= instr_nxt[7:0];
               end else begin
                  cnt_r <= 4'(cnt_r + 4'h1);
               end
            end
            SCP_DATA: begin
               dsh_r <= byte_nxt;
               if (cnt_r == 4'h7) begin
                  cnt_r  <= 4'h0;
                  addr_r <= addr_nxt;
                  if (last_byte) begin
                     state_r <= SCP_DONE;
                  end else if (len_r != LEN_STREAM) begin
                     left_r <= 2'(left_r - 2'h1);
                  end
               end else begin
                  cnt_r <= 4'(cnt_r + 4'h1);
               end
            end
            SCP_DONE: begin
               cnt_r <= 4'h0;
            end
            default: begin
               state_r <= SCP_IDLE;
            end
         endcase
      end
   end

   // Register array, written at the eighth rising edge of each write byte
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= REG_RESET;
         end
         mem[CFG_ADDR] <= CFG_RESET;
      end else if (byte_end && !rd_r) begin
         mem[addr_r] <= byte_nxt;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         upd_r      <= 1'b0;
         upd_addr_r <= 8'h00;
         upd_data_r <= 8'h00;
      end else begin
         upd_r <= byte_end && !rd_r;
         if (byte_end && !rd_r) begin
            upd_addr_r <= addr_r;
            upd_data_r <= byte_nxt;
         end
      end
   end

   // Read data follows the falling edge, or a resume after a stall
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sdo_r <= 1'b0;
         oe_r  <= 1'b0;
      end else if (cs_s_r || state_r != SCP_DATA || !rd_r) begin
         oe_r <= 1'b0;
      end else if (fall || cs_fall) begin
         oe_r  <= 1'b1;
         sdo_r <= mem[addr_r][bidx];
      end
   end

   assign link.dev_sdio = sdo_r;
   assign link.dev_oe   = oe_r;
   assign lsb_first_o   = lsb;
   assign busy_o        = (state_r != SCP_IDLE);
   assign upd_valid_o   = upd_r;
   assign upd_addr_o    = upd_addr_r;
   assign upd_data_o    = upd_data_r;
endmodule : scp_device

// ### design/scp_host.sv
// Host controller that runs port transfers on orders taken over APB
module scp_host
   import scp_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   scp_if.host              link
);
   typedef enum logic [2:0] {
      H_IDLE,
      H_SETUP,
      H_LOW,
      H_HIGH,
      H_HOLD
   } scp_hstate_t;

   scp_hstate_t state_r;
   logic        rw_r;
   logic [1:0]  len_r;
   logic        lsb_r;
   logic [12:0] addr_r;
   logic [31:0] txd_r;
   logic [31:0] rxd_r;
   logic        done_r;
   logic [31:0] prdata_r;
   logic [7:0]  tmr_r;
   logic [5:0]  bitn_r;
   logic [5:0]  total;
   logic        sclk_r;
   logic        cs_n_r;
   logic        sdo_r;
   logic        oe_r;
   logic        sdi_m_r;
   logic        sdi_s_r;
   logic        acc;
   logic        wr;
   logic        mapped;
   logic        go;
   logic [15:0] instr;
   logic [5:0]  nidx;
   logic [5:0]  d;

   assign acc    = psel_i & penable_i;
   assign wr     = acc & pwrite_i & (state_r == H_IDLE);
   assign mapped = (paddr_i == OFS_CTRL) || (paddr_i == OFS_ADDR) || (paddr_i == OFS_TXD) ||
                   (paddr_i == OFS_RXD) || (paddr_i == OFS_STAT);
   assign go     = wr && (paddr_i == OFS_CTRL) && pwdata_i[CTRL_GO];
   assign instr  = {rw_r, len_r, 5'h00, addr_r[7:0]};
   assign total  = (len_r == LEN_STREAM) ? 6'(INSTR_BITS + 8 * STREAM_BYTES)
                                         : 6'(INSTR_BITS + 8 * (len_r + 2'h1));
   assign nidx   = (state_r == H_SETUP) ? 6'h00 : 6'(bitn_r + 6'h01);
   assign d      = 6'(bitn_r - 6'(INSTR_BITS));

   function automatic logic txbit(input logic [5:0] k);
      logic [5:0] e;
      e = 6'(k - 6'(INSTR_BITS));
      if (k < 6'(INSTR_BITS)) begin
         txbit = lsb_r ? instr[k[3:0]] : instr[4'(4'hF - k[3:0])];
      end else begin
         txbit = txd_r[{e[4:3], lsb_r ? e[2:0] : 3'(3'h7 - e[2:0])}];
      end
   endfunction : txbit

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rw_r   <= 1'b0;
         len_r  <= 2'h0;
         lsb_r  <= 1'b0;
         addr_r <= 13'h0000;
         txd_r  <= 32'h00000000;
      end else if (wr) begin
         case (paddr_i)
            OFS_CTRL: begin
               rw_r  <= pwdata_i[CTRL_RW];
               len_r <= pwdata_i[CTRL_LEN+1:CTRL_LEN];
               lsb_r <= pwdata_i[CTRL_LSB];
            end
            OFS_ADDR: addr_r <= pwdata_i[ADDR_W-1:0];
            OFS_TXD:  txd_r <= pwdata_i;
            default:  txd_r <= txd_r;
         endcase
      end
   end

   // Read data is set up in the setup cycle so zero-wait access phases see it
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_r <= 32'h00000000;
      end else if (psel_i && !penable_i) begin
         case (paddr_i)
            OFS_CTRL: prdata_r <= 32'({lsb_r, len_r, rw_r, 1'b0});
            OFS_ADDR: prdata_r <= 32'(addr_r);
            OFS_TXD:  prdata_r <= txd_r;
            OFS_RXD:  prdata_r <= rxd_r;
            OFS_STAT: prdata_r <= 32'({done_r, state_r != H_IDLE});
            default:  prdata_r <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sdi_m_r <= 1'b0;
         sdi_s_r <= 1'b0;
      end else begin
         sdi_m_r <= link.sdio;
         sdi_s_r <= sdi_m_r;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= H_IDLE;
         tmr_r   <= 8'h00;
         bitn_r  <= 6'h00;
         sclk_r  <= 1'b0;
         cs_n_r  <= 1'b1;
         sdo_r   <= 1'b0;
         oe_r    <= 1'b0;
         done_r  <= 1'b0;
         rxd_r   <= 32'h00000000;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (go) begin
                  done_r  <= 1'b0;
                  cs_n_r  <= 1'b0;
                  tmr_r   <= 8'(CS_SETUP_CYC);
                  state_r <= H_SETUP;
               end
            end
            H_SETUP, H_HIGH: begin
               if (tmr_r > 8'h01) begin
                  tmr_r <= 8'(tmr_r - 8'h01);
               end else if (state_r == H_HIGH && bitn_r == 6'(total - 6'h01)) begin
                  sclk_r  <= 1'b0;
                  oe_r    <= 1'b0;
                  tmr_r   <= 8'(CS_HOLD_CYC);
                  state_r <= H_HOLD;
               end else begin
                  sclk_r  <= 1'b0;
                  bitn_r  <= nidx;
                  sdo_r   <= txbit(nidx);
                  oe_r    <= (nidx < 6'(INSTR_BITS)) || !rw_r;
                  tmr_r   <= 8'(SCLK_HALF_CYC);
                  state_r <= H_LOW;
               end
            end
            H_LOW: begin
               if (tmr_r > 8'h01) begin
                  tmr_r <= 8'(tmr_r - 8'h01);
               end else begin
                  sclk_r  <= 1'b1;
                  tmr_r   <= 8'(SCLK_HALF_CYC);
                  state_r <= H_HIGH;
                  if (rw_r && bitn_r >= 6'(INSTR_BITS)) begin
                     rxd_r[{d[4:3], lsb_r ? d[2:0] : 3'(3'h7 - d[2:0])}] <= sdi_s_r;
                  end
               end
            end
            H_HOLD: begin
               if (tmr_r > 8'h01) begin
                  tmr_r <= 8'(tmr_r - 8'h01);
               end else begin
                  cs_n_r  <= 1'b1;
                  done_r  <= 1'b1;
                  state_r <= H_IDLE;
               end
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   assign prdata_o       = prdata_r;
   assign pready_o       = 1'b1;
   assign pslverr_o      = acc & ~mapped;
   assign link.sclk      = sclk_r;
   assign link.cs_n      = cs_n_r;
   assign link.host_sdio = sdo_r;
   assign link.host_oe   = oe_r;
endmodule : scp_host

// ### tb/scp_link_asserts.sv
// Concurrent checks on the pins between the port device and its host controller
module scp_link_asserts
   import scp_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic host_sdio_i,
   input wire logic host_oe_i,
   input wire logic dev_sdio_i,
   input wire logic dev_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sclk_r;
   logic [7:0] rise_cnt_r;

   // Rising serial clock edges seen within the current frame
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_r     <= 1'b0;
         rise_cnt_r <= 8'h00;
      end else begin
         sclk_r <= sclk_i;
         if (cs_n_i) begin
            rise_cnt_r <= 8'h00;
         end else if (sclk_i && !sclk_r) begin
            rise_cnt_r <= rise_cnt_r + 8'h01;
         end
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_frame_start;
      !sclk_i[*8] ##2 sclk_i;
   endsequence
   sequence s_high_half;
      sclk_i[*8] ##1 !sclk_i;
   endsequence

   chk_pin_fight: assert property (!(dev_oe_i && host_oe_i))
      else $error("both ends drive the data pin");
   chk_idle_lines: assert property (cs_n_i |-> !sclk_i && !host_oe_i)
      else $error("clock or host data active while deselected");
   chk_idle_release: assert property (cs_n_i[*6] |-> !dev_oe_i)
      else $error("device drives the pin while deselected");
   chk_start_order: assert property ($fell(cs_n_i) |-> s_frame_start)
      else $error("frame did not start with select then rising clock");
   chk_clock_half: assert property ($rose(sclk_i) |-> s_high_half)
      else $error("serial clock high half has wrong length");
   chk_write_stable: assert property (sclk_i && host_oe_i |-> $stable(host_sdio_i))
      else $error("host data moved while clock high");
   chk_read_stable: assert property (sclk_i && dev_oe_i |-> $stable(dev_sdio_i))
      else $error("read data moved while clock high");
   chk_read_phase: assert property ($rose(dev_oe_i) |->
      rise_cnt_r == 8'h10 && !host_oe_i)
      else $error("device drove outside the read data phase");
   chk_frame_bits: assert property ($rose(cs_n_i) |->
      rise_cnt_r inside {8'h18, 8'h20, 8'h28, 8'h30})
      else $error("frame length is not instruction plus whole bytes");
endmodule : scp_link_asserts

// ### tb/test_serial_control_port.sv
// Self-checking bench: APB-driven host controller facing the port device
module test_serial_control_port
   import scp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        rw;
      logic [1:0]  len;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [31:0] exp;
   } scp_row_t;

   logic        mclk = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        lsb_first;
   logic        busy;
   logic        upd_valid;
   logic [7:0]  upd_addr;
   logic [7:0]  upd_data;
   int          bad_count = 0;
   int          total_checks = 0;
   int          upd_n = 0;
   int          upd_base = 0;
   logic [31:0] rx;
   logic        e;

   // Writes expect {byte count, last address, last data}; reads expect the received bytes
   scp_row_t rows [8] = '{
      '{1'b0, 2'h0, 8'h10, 32'h0000005A, 32'h0001105A},
      '{1'b0, 2'h1, 8'h21, 32'h00003CC3, 32'h0002203C},
      '{1'b0, 2'h2, 8'h32, 32'h00112233, 32'h00033011},
      '{1'b1, 2'h0, 8'h10, 32'h0, 32'h0000005A},
      '{1'b1, 2'h1, 8'h21, 32'h0, 32'h00003CC3},
      '{1'b1, 2'h2, 8'h32, 32'h0, 32'h00112233},
      '{1'b1, 2'h0, 8'h00, 32'h0, 32'h00000018},
      '{1'b1, 2'h0, 8'h55, 32'h0, 32'h00000000}};

   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      if (upd_valid === 1'b1) begin
         upd_n++;
      end
   end

   scp_if link ();
   scp_device scp_device_inst (.mclk_i(mclk), .rstn_i(rstn), .link(link.dev),
      .lsb_first_o(lsb_first), .busy_o(busy), .upd_valid_o(upd_valid),
      .upd_addr_o(upd_addr), .upd_data_o(upd_data));
   scp_host scp_host_inst (.mclk_i(mclk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .link(link.host));
   scp_link_asserts scp_link_asserts_inst (.mclk_i(mclk), .rstn_i(rstn), .sclk_i(link.sclk),
      .cs_n_i(link.cs_n), .host_sdio_i(link.host_sdio), .host_oe_i(link.host_oe),
      .dev_sdio_i(link.dev_sdio), .dev_oe_i(link.dev_oe));

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         bad_count++;
         complete_run();
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Runs one port frame and waits for the controller to report it finished
   task automatic xfer(input scp_row_t r, input logic lsb, output logic [31:0] q);
      logic [31:0] st;
      logic        er;
      int          n;
      apb(1'b1, OFS_ADDR, {24'h0, r.addr}, st, er);
      apb(1'b1, OFS_TXD, r.data, st, er);
      upd_base = upd_n;
      apb(1'b1, OFS_CTRL, {27'h0, lsb, r.len, r.rw, 1'b1}, st, er);
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0, st, er);
         n++;
      end while (st[STAT_DONE] !== 1'b1 && n < 2000);
      if (n >= 2000) begin
         bad_count++;
         complete_run();
      end
      chk({30'h0, st[1:0]}, 32'h2);
      apb(1'b0, OFS_RXD, 32'h0, q, er);
   endtask : xfer

   function automatic logic [31:0] upd_word();
      return {8'h0, 8'(upd_n - upd_base), upd_addr, upd_data};
   endfunction : upd_word

   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      apb(1'b0, OFS_STAT, 32'h0, rx, e);
      chk(rx, 32'h0);
      chk({31'h0, lsb_first}, 32'h0);
      apb(1'b0, 8'h14, 32'h0, rx, e);
      chk({rx[30:0], e}, 32'h1);
      $display("test reset and unmapped done");
      for (int i = 0; i < 8; i++) begin
         xfer(rows[i], 1'b0, rx);
         if (rows[i].rw) begin
            chk(rx & ((32'h1 << (8 * (rows[i].len + 1))) - 1), rows[i].exp);
         end else begin
            chk(upd_word(), rows[i].exp);
         end
         $display("test row %0d done", i);
      end
      // Streaming write down from 0x01 must stop after 0xFF; 0x00 gets a mirrored value
      xfer('{1'b0, 2'h3, 8'h01, 32'h337E18A1, 32'h0}, 1'b0, rx);
      chk(upd_word(), 32'h0003FF7E);
      xfer('{1'b1, 2'h0, 8'hFF, 32'h0, 32'h0}, 1'b0, rx);
      chk(rx & 32'hFF, 32'h7E);
      // Streaming read cut by select before 0xFF; the next frame must start clean
      xfer('{1'b1, 2'h3, 8'h21, 32'h0, 32'h0}, 1'b0, rx);
      chk(rx, 32'h00003CC3);
      xfer('{1'b1, 2'h0, 8'h10, 32'h0, 32'h0}, 1'b0, rx);
      chk(rx & 32'hFF, 32'h5A);
      $display("test stream write done");
      xfer('{1'b0, 2'h0, 8'h00, 32'h66, 32'h0}, 1'b0, rx);
      chk({31'h0, lsb_first}, 32'h1);
      xfer('{1'b0, 2'h1, 8'hFD, 32'h2211, 32'h0}, 1'b1, rx);
      chk(upd_word(), 32'h0002FE22);
      xfer('{1'b1, 2'h3, 8'hFD, 32'h0, 32'h0}, 1'b1, rx);
      chk(rx & 32'hFFFFFF, 32'h7E2211);
      xfer('{1'b0, 2'h0, 8'h00, 32'h18, 32'h0}, 1'b1, rx);
      chk({31'h0, lsb_first}, 32'h0);
      $display("test lsb first done");
      // Mid-run reset must return the register array to its reset values and leave the link deselected
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      chk({31'h0, link.cs_n}, 32'h1);
      xfer('{1'b1, 2'h0, 8'h10, 32'h0, 32'h0}, 1'b0, rx);
      chk(rx & 32'hFF, 32'h0);
      $display("test mid-run reset done");
      complete_run();
   end
endmodule : test_serial_control_port
